/* File: rtl/arwsc_ctrl.sv */
// Converter control: prescaler, start logic, accumulation, window flag, sleep.
// Assumes the analog core presents a 10-bit code in sample_code_in when a
// conversion ends; event_in comes from the event system on another clock.
`timescale 1ns/1ps
module arwsc_ctrl
   import arwsc_pkg::*;
(
   input wire logic clk_in, // Peripheral clock, 25 MHz
   input wire logic rst_in, // Async reset, active high
   input wire logic enable_in, // Converter enable
   input wire logic [2:0] prescaler_select_in, // Clock divide 2..64
   input wire logic [2:0] accumulation_count_select_in, // 1..64 results
   input wire logic [4:0] positive_input_select_in, // Channel select
   input wire logic [1:0] reference_select_in, // Reference select
   input wire logic [2:0] window_condition_select_in, // Window mode
   input wire logic [RES_W-1:0] window_low_threshold_in, // Lower threshold
   input wire logic [RES_W-1:0] window_high_threshold_in, // Upper threshold
   input wire logic start_conversion_write_in, // Software writes start bit
   input wire logic start_event_input_enable_in, // Event start enable
   input wire logic event_in, // Event line, asynchronous
   input wire logic [1:0] interrupt_enable_in, // Bit0 ready, bit1 window
   input wire logic [1:0] flag_clear_in, // Write-one-to-clear pulses
   input wire logic result_read_in, // Result read pulse
   input wire logic global_irq_enable_in, // Global interrupt enable
   input wire logic touch_enable_in, // Touch controller owns converter
   input wire logic standby_in, // Standby sleep
   input wire logic power_down_in, // Power-down sleep
   input wire logic run_in_standby_in, // Keep running in standby
   input wire logic [CODE_W-1:0] sample_code_in, // Code from analog core
   output logic [RES_W-1:0] conversion_result_out, // Result register
   output logic result_ready_flag_out, // Ready flag
   output logic window_compare_flag_out, // Window flag
   output logic start_conversion_bit_out, // Start bit status
   output logic irq_out, // Interrupt request
   output logic [7:0] irq_vector_out, // Vector offset of pending source
   output logic temp_sensor_enable_out, // Temperature sensor on
   output logic [4:0] mux_select_out, // Channel latched for conversion
   output logic [1:0] ref_select_out, // Reference latched for conversion
   output logic clock_request_out, // Peripheral clock request
   output logic result_invalid_out // Last result cut by power-down
);
   logic ev_meta_reg, ev_sync_reg, ev_prev_reg;
   logic [5:0] presc_reg, presc_next;
   logic [3:0] cyc_reg, cyc_next;
   logic [6:0] acc_cnt_reg;
   logic [RES_W-1:0] acc_sum_reg;
   arwsc_state_t state_reg, state_next;
   logic from_event_reg, halted_reg;
   logic start_conversion_bit_reg;
   logic [4:0] mux_reg;
   logic [1:0] ref_reg;
   logic ready_reg, window_compare_flag_reg;
   logic [RES_W-1:0] result_reg;
   logic win_match;
   arwsc_window_t win;
   arwsc_sleep_t sleep;

   // Event line crosses from another domain: two flops before any logic.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ev_meta_reg <= 1'b0;
         ev_sync_reg <= 1'b0;
         ev_prev_reg <= 1'b0;
      end else begin
         ev_meta_reg <= event_in;
         ev_sync_reg <= ev_meta_reg;
         ev_prev_reg <= ev_sync_reg;
      end
   end

   assign sleep = '{standby: standby_in, power_down: power_down_in,
                    run_in_standby: run_in_standby_in};
   assign win = '{low: window_low_threshold_in, high: window_high_threshold_in,
                  mode: window_condition_select_in};
   wire ev_rise = ev_sync_reg && !ev_prev_reg;
   wire standby_off = sleep.standby && !sleep.run_in_standby;
   wire may_start = enable_in && !touch_enable_in && !sleep.power_down && !standby_off;
   wire sw_start = start_conversion_write_in && !sleep.standby;
   wire ev_start = start_event_input_enable_in && ev_rise;
   wire acc_reserved = accumulation_count_select_in == ACC_RESERVED;
   wire start_req = may_start && (sw_start || ev_start) && !acc_reserved;
   // Power-down freezes the converter mid-flight rather than aborting it.
   wire frozen = sleep.power_down;
   wire [5:0] presc_top = 6'((7'h02 << prescaler_select_in) - 7'h01);
   wire adc_tick = (presc_reg == presc_top) && !frozen;
   wire [6:0] acc_total = 7'(7'h01 << accumulation_count_select_in);
   wire last_cycle = adc_tick && (cyc_reg == CONV_ADC_CYCLES - 4'h1);
   wire conv_end = (state_reg == ARWSC_CONV) && last_cycle;
   wire last_sample = acc_cnt_reg == acc_total - 7'h01;
   wire final_done = conv_end && last_sample;
   // Code is already the ratio 1024*Vin/Vref from the analog core.
   wire [RES_W-1:0] code_ext = {{(RES_W-CODE_W){1'b0}}, sample_code_in};
   wire [RES_W-1:0] sum_next = 16'(acc_sum_reg + code_ext);

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ARWSC_IDLE: if (start_req) state_next = ARWSC_CONV;
         ARWSC_CONV: if (final_done) state_next = ARWSC_DONE;
         ARWSC_DONE: state_next = ARWSC_IDLE;
         default: state_next = ARWSC_IDLE;
      endcase
   end

   // Prescaler restarts on a trigger so the start has a fixed delay.
   assign presc_next = (state_reg == ARWSC_IDLE || !enable_in) ? 6'h00 :
                       frozen ? presc_reg : adc_tick ? 6'h00 : 6'(presc_reg + 6'h01);
   assign cyc_next = (state_reg != ARWSC_CONV) ? 4'h0 :
                     last_cycle ? 4'h0 : adc_tick ? 4'(cyc_reg + 4'h1) : cyc_reg;

   arwsc_window_cmp u_win (
      .result_in(sum_next),
      .win_in(win),
      .match_out(win_match)
   );

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= ARWSC_IDLE;
         presc_reg <= 6'h00;
         cyc_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         presc_reg <= presc_next;
         cyc_reg <= cyc_next;
      end
   end

   // Accumulator and result load.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         acc_cnt_reg <= ACC_RESET;
         acc_sum_reg <= '0;
         result_reg <= '0;
      end else if (state_reg == ARWSC_IDLE) begin
         acc_cnt_reg <= ACC_RESET;
         acc_sum_reg <= '0;
      end else if (conv_end) begin
         acc_cnt_reg <= last_sample ? ACC_RESET : 7'(acc_cnt_reg + 7'h01);
         acc_sum_reg <= last_sample ? '0 : sum_next;
         if (last_sample) result_reg <= sum_next;
      end
   end

   // Flags: a hardware set in the same cycle as a clear wins.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ready_reg <= 1'b0;
         window_compare_flag_reg <= 1'b0;
      end else begin
         ready_reg <= final_done ||
                      (ready_reg && !flag_clear_in[FLAG_RESULT_READY_FLAG_BIT] && !result_read_in);
         window_compare_flag_reg <= (final_done && win_match) ||
                      (window_compare_flag_reg && !flag_clear_in[FLAG_WINDOW_COMPARE_FLAG_BIT]);
      end
   end

   // Start bit, channel lock, event origin and power-down marker.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         start_conversion_bit_reg <= 1'b0;
         from_event_reg <= 1'b0;
         halted_reg <= 1'b0;
         mux_reg <= 5'h00;
         ref_reg <= 2'h0;
      end else begin
         if (state_reg == ARWSC_IDLE) begin
            // Selections track software until a conversion locks them.
            mux_reg <= positive_input_select_in;
            ref_reg <= reference_select_in;
            if (start_req) begin
               start_conversion_bit_reg <= 1'b1;
               from_event_reg <= ev_start;
               halted_reg <= 1'b0;
            end
         end else if (final_done) begin
            start_conversion_bit_reg <= 1'b0;
         end
         if (state_reg == ARWSC_CONV && frozen) halted_reg <= 1'b1;
      end
   end

   assign conversion_result_out = result_reg;
   assign result_ready_flag_out = ready_reg;
   assign window_compare_flag_out = window_compare_flag_reg;
   assign start_conversion_bit_out = start_conversion_bit_reg;
   assign mux_select_out = mux_reg;
   assign ref_select_out = ref_reg;
   assign result_invalid_out = halted_reg;
   assign temp_sensor_enable_out = enable_in && mux_reg == MUX_TEMP_SENSOR;
   assign clock_request_out = state_reg != ARWSC_IDLE || start_req;
   wire ready_irq = ready_reg && interrupt_enable_in[FLAG_RESULT_READY_FLAG_BIT];
   wire window_compare_flag_irq = window_compare_flag_reg && interrupt_enable_in[FLAG_WINDOW_COMPARE_FLAG_BIT];
   assign irq_out = global_irq_enable_in && (ready_irq || window_compare_flag_irq);
   assign irq_vector_out = ready_irq ? IRQ_VEC_RESULT_READY_FLAG : IRQ_VEC_WINDOW_COMPARE_FLAG;

   // Ticks counted apart from the cycle counter, so the length check is not circular.
   logic [4:0] tick_cnt_reg;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tick_cnt_reg <= 5'h00;
      end else if (state_reg != ARWSC_CONV || conv_end) begin
         tick_cnt_reg <= 5'h00;
      end else if (adc_tick) begin
         tick_cnt_reg <= 5'(tick_cnt_reg + 5'h01);
      end
   end

   sequence ready_set_s;
      $rose(ready_reg);
   endsequence

   sequence frozen_busy_s;
      frozen && state_reg == ARWSC_CONV;
   endsequence

   ready_load_a: assert property (@(posedge clk_in) disable iff (rst_in)
      final_done |=> ready_reg && result_reg == $past(sum_next))
      else $error("result not loaded with ready flag");
   ready_cause_a: assert property (@(posedge clk_in) disable iff (rst_in)
      ready_set_s |-> $past(final_done))
      else $error("ready flag set without completion");
   ready_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (result_read_in && !final_done) |=> !ready_reg)
      else $error("ready flag not cleared by read");
   window_once_a: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(window_compare_flag_reg) |-> $past(final_done && win_match))
      else $error("window flag outside final result");
   window_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (window_condition_select_in == 3'h0) |-> !win_match)
      else $error("comparator active in mode zero");
   touch_block_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (touch_enable_in && state_reg == ARWSC_IDLE) |=> state_reg == ARWSC_IDLE)
      else $error("conversion started under touch control");
   event_start_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (ev_start && may_start && !acc_reserved && state_reg == ARWSC_IDLE)
      |=> start_conversion_bit_reg && state_reg == ARWSC_CONV)
      else $error("event edge did not start conversion");
   start_conversion_bit_end_a: assert property (@(posedge clk_in) disable iff (rst_in)
      final_done |=> !start_conversion_bit_reg)
      else $error("start bit not cleared at end");
   freeze_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (frozen && state_reg == ARWSC_CONV) |=> $stable(cyc_reg) && $stable(presc_reg))
      else $error("conversion advanced in power-down");
   conv_len_a: assert property (@(posedge clk_in) disable iff (rst_in)
      conv_end |-> tick_cnt_reg == 5'h0c)
      else $error("conversion length not 13 cycles");

   conv_max_a: assert property (@(posedge clk_in) disable iff (rst_in)
      tick_cnt_reg <= 5'h0c)
      else $error("conversion ran past 13 cycles");

   halt_mark_a: assert property (@(posedge clk_in) disable iff (rst_in)
      frozen_busy_s |=> halted_reg)
      else $error("power-down hit not marked");

   halt_ready_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (final_done && halted_reg) |=> ready_reg)
      else $error("halted conversion did not flag ready");

   pd_start_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (frozen && state_reg == ARWSC_IDLE) |=> state_reg == ARWSC_IDLE)
      else $error("conversion started in power-down");

   reserved_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (acc_reserved && state_reg == ARWSC_IDLE) |=> state_reg == ARWSC_IDLE)
      else $error("start with reserved accumulation");

   standby_run_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (state_reg == ARWSC_CONV && !frozen && enable_in) |=> state_reg != ARWSC_IDLE)
      else $error("ongoing conversion aborted");

   sw_standby_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (sleep.standby && !ev_start && state_reg == ARWSC_IDLE) |=> state_reg == ARWSC_IDLE)
      else $error("software start taken in standby");

   clk_req_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (state_reg != ARWSC_IDLE) |-> clock_request_out)
      else $error("clock not requested while busy");

   event_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (!start_event_input_enable_in && !sw_start && state_reg == ARWSC_IDLE)
      |=> state_reg == ARWSC_IDLE)
      else $error("conversion started with no trigger");

   start_conversion_bit_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (state_reg == ARWSC_CONV) |-> start_conversion_bit_reg)
      else $error("start bit low during conversion");

   irq_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (global_irq_enable_in && ready_reg && interrupt_enable_in[FLAG_RESULT_READY_FLAG_BIT]) |-> irq_out)
      else $error("interrupt request dropped while flagged");

   vector_ready_a: assert property (@(posedge clk_in) disable iff (rst_in)
      ready_irq |-> irq_vector_out == IRQ_VEC_RESULT_READY_FLAG)
      else $error("wrong vector for ready");

   vector_win_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (!ready_irq && window_compare_flag_irq) |-> irq_vector_out == IRQ_VEC_WINDOW_COMPARE_FLAG)
      else $error("wrong vector for window");

   temp_sensor_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (enable_in && mux_reg == MUX_TEMP_SENSOR) |-> temp_sensor_enable_out)
      else $error("temperature sensor not enabled");

   select_lock_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (state_reg != ARWSC_IDLE) |=> $stable(mux_reg) && $stable(ref_reg))
      else $error("selection changed during conversion");
   irq_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
      !global_irq_enable_in |-> !irq_out)
      else $error("interrupt without global enable");
   standby_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (standby_off && state_reg == ARWSC_IDLE) |=> state_reg == ARWSC_IDLE)
      else $error("conversion started in standby without run bit");
endmodule

/* File: rtl/arwsc_pkg.sv */
// Package for the converter control block: field layouts, codes and counts.
// Assumes a single 25 MHz peripheral clock; no register bus, all controls are ports.
package arwsc_pkg;
   localparam int RES_W = 16;
   localparam int CODE_W = 10;
   localparam logic [CODE_W-1:0] CODE_MIN = 10'h000;
   localparam logic [CODE_W-1:0] CODE_MAX = 10'h3ff;
   localparam logic [4:0] MUX_TEMP_SENSOR = 5'h1e;
   localparam logic [1:0] REF_INTERNAL = 2'h0;
   localparam logic [2:0] ACC_RESERVED = 3'h7;
   localparam logic [3:0] CONV_ADC_CYCLES = 4'hd;
   localparam logic [2:0] PRESC_RESET = 3'h0;
   localparam logic [6:0] ACC_RESET = 7'h00;
   localparam logic [7:0] IRQ_VEC_RESULT_READY_FLAG = 8'h00;
   localparam logic [7:0] IRQ_VEC_WINDOW_COMPARE_FLAG = 8'h02;
   localparam int FLAG_RESULT_READY_FLAG_BIT = 0;
   localparam int FLAG_WINDOW_COMPARE_FLAG_BIT = 1;

   typedef enum logic [2:0] {
      ARWSC_WIN_OFF = 3'b000,
      ARWSC_WIN_BELOW = 3'b001,
      ARWSC_WIN_ABOVE = 3'b010,
      ARWSC_WIN_INSIDE = 3'b011,
      ARWSC_WIN_OUTSIDE = 3'b100
   } arwsc_win_t;

   typedef enum logic [1:0] {
      ARWSC_IDLE = 2'b00,
      ARWSC_CONV = 2'b01,
      ARWSC_DONE = 2'b10
   } arwsc_state_t;

   typedef struct packed {
      logic [RES_W-1:0] low;
      logic [RES_W-1:0] high;
      logic [2:0] mode;
   } arwsc_window_t;

   typedef struct packed {
      logic standby;
      logic power_down;
      logic run_in_standby;
   } arwsc_sleep_t;
endpackage

/* File: rtl/arwsc_window_cmp.sv */
// Window comparator: combinational test of a result against two thresholds.
// Assumes the caller samples the match only on a final accumulated result.
`timescale 1ns/1ps
module arwsc_window_cmp
   import arwsc_pkg::*;
(
   input wire logic [RES_W-1:0] result_in, // Final result
   input wire arwsc_window_t win_in, // Thresholds and mode
   output logic match_out // Condition holds
);
   wire below_low = result_in < win_in.low;
   wire above_high = result_in > win_in.high;
   wire above_low = result_in > win_in.low;
   wire below_high = result_in < win_in.high;
   always_comb begin
      unique case (win_in.mode)
         ARWSC_WIN_BELOW: match_out = below_low;
         ARWSC_WIN_ABOVE: match_out = above_high;
         ARWSC_WIN_INSIDE: match_out = above_low && below_high;
         ARWSC_WIN_OUTSIDE: match_out = below_low || above_high;
         default: match_out = 1'b0;
      endcase
   end
endmodule

/* File: verification/arwsc_ctrl_src_model.sv */
// Far-side model: analog source presenting a code, and an event channel.
// Assumes the bench sets the level between conversions and asks for events.
`timescale 1ns/1ps
module arwsc_ctrl_src_model
   import arwsc_pkg::*;
(
   input wire logic clk_in, // Peripheral clock
   input wire logic rst_in, // Async reset, active high
   input wire logic [CODE_W-1:0] level_in, // Code the source settles to
   input wire logic fire_in, // Request one event
   output logic [CODE_W-1:0] sample_code_out, // Code seen by the converter
   output logic event_out // Event line
);
   logic [2:0] hold_reg;
   // Source holds its level, so every accumulated sample reads the same code
   assign sample_code_out = level_in;
   // Event stays high long enough for the two-flop synchroniser to see an edge
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) hold_reg <= 3'h0;
      else if (fire_in) hold_reg <= 3'h4;
      else if (hold_reg != 3'h0) hold_reg <= hold_reg - 3'h1;
   end
   assign event_out = (hold_reg != 3'h0);
endmodule

/* File: verification/arwsc_ctrl_tb_top.sv */
// Self-checking bench for the converter control block.
// Uses divide-by-2 prescaler, so one conversion is about 27 clocks, except the event tests at divide 2, 4 or 8.
`timescale 1ns/1ps
module arwsc_ctrl_tb_top;
   import arwsc_pkg::*;
   logic clk_in, rst_in, enable_in, sw_start, estart, evt, gie, touch, stby, pdown, runsb, fire;
   logic rd_in;
   logic [2:0] presc, acc, wmode;
   logic [4:0] mux;
   logic [1:0] reference_select, ien, fclr;
   logic [RES_W-1:0] lo, hi, res;
   logic [CODE_W-1:0] level, code;
   logic rdy, wflag, sbit, irq, tsen, creq, inval;
   logic [7:0] vec;
   logic [4:0] muxo;
   logic [1:0] refo;
   int bad_count, num_checks, n;
   arwsc_ctrl dut (.clk_in(clk_in), .rst_in(rst_in), .enable_in(enable_in),
      .prescaler_select_in(presc), .accumulation_count_select_in(acc),
      .positive_input_select_in(mux), .reference_select_in(reference_select),
      .window_condition_select_in(wmode), .window_low_threshold_in(lo),
      .window_high_threshold_in(hi), .start_conversion_write_in(sw_start),
      .start_event_input_enable_in(estart), .event_in(evt), .interrupt_enable_in(ien),
      .flag_clear_in(fclr), .result_read_in(rd_in), .global_irq_enable_in(gie),
      .touch_enable_in(touch), .standby_in(stby), .power_down_in(pdown),
      .run_in_standby_in(runsb), .sample_code_in(code), .conversion_result_out(res),
      .result_ready_flag_out(rdy), .window_compare_flag_out(wflag),
      .start_conversion_bit_out(sbit), .irq_out(irq), .irq_vector_out(vec),
      .temp_sensor_enable_out(tsen), .mux_select_out(muxo), .ref_select_out(refo),
      .clock_request_out(creq), .result_invalid_out(inval));
   arwsc_ctrl_src_model src (.clk_in(clk_in), .rst_in(rst_in), .level_in(level),
      .fire_in(fire), .sample_code_out(code), .event_out(evt));
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic test_done();
      $display("Checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Bounded wait for the ready flag; a timeout counts and ends the run
   task automatic wait_rdy();
      int i;
      for (i = 0; i < 2000 && rdy !== 1'b1; i++) @(negedge clk_in);
      if (rdy !== 1'b1) begin
         bad_count++;
         $display("Error ready wait expected 1 seen %b", rdy);
         test_done();
      end
   endtask
   task automatic pulse_start();
      sw_start = 1'b1;
      @(negedge clk_in);
      sw_start = 1'b0;
   endtask
   task automatic clear_flags();
      fclr = 2'h3;
      @(negedge clk_in);
      fclr = 2'h0;
      @(negedge clk_in);
   endtask
   // Start must be dropped silently: no flag within a full conversion time
   task automatic refused(input string what);
      clear_flags();
      pulse_start();
      repeat (60) @(negedge clk_in);
      chk(what, 16'h0, {15'h0, rdy});
   endtask
   function automatic logic win_exp(int m, int r, int l, int h);
      case (m)
         1: return r < l;
         2: return r > h;
         3: return r > l && r < h;
         4: return r < l || r > h;
         default: return 1'b0;
      endcase
   endfunction
   initial begin
      {enable_in, sw_start, estart, gie, touch, stby, pdown, runsb, fire, rd_in} = '0;
      presc = 3'h0; acc = 3'h0; wmode = 3'h0; mux = 5'h00; reference_select = 2'h1;
      ien = 2'h0; fclr = 2'h0; lo = 16'h0; hi = 16'h0; level = 10'h0;
      bad_count = 0; num_checks = 0;
      rst_in = 1'b1;
      repeat (6) @(negedge clk_in);
      rst_in = 1'b0;
      chk("reset ready", 16'h0, {15'h0, rdy});
      chk("reset irq", 16'h0, {15'h0, irq});
      chk("reset vector", 16'h2, {8'h0, vec});
      enable_in = 1'b1;
      void'($urandom(84));
      // Accumulated software conversions with every window mode
      for (int a = 0; a < 3; a++) begin
         for (int m = 0; m < 5; m++) begin
            acc = a[2:0]; wmode = m[2:0];
            level = (m == 0) ? ((a == 0) ? 10'h3ff : 10'h000) : 10'($urandom_range(1023));
            n = 1 << a;
            lo = 16'($urandom_range(n * 1024)); hi = 16'($urandom_range(n * 1024));
            if (m == 3) begin lo = 16'(n * level) - 16'h1; hi = 16'(n * level) + 16'h1; end
            mux = (m == 2) ? MUX_TEMP_SENSOR : 5'h03; reference_select = (m == 2) ? REF_INTERNAL : 2'h1;
            clear_flags();
            pulse_start();
            chk("start bit", 16'h1, {15'h0, sbit});
            chk("temp sensor", {15'h0, m == 2}, {15'h0, tsen});
            chk("mux lock", {11'h0, mux}, {11'h0, muxo});
            chk("ref lock", {14'h0, reference_select}, {14'h0, refo});
            wait_rdy();
            chk("result", 16'(n * level), res);
            chk("window flag", {15'h0, win_exp(m, n * level, lo, hi)}, {15'h0, wflag});
            chk("start bit end", 16'h0, {15'h0, sbit});
            chk("result valid", 16'h0, {15'h0, inval});
         end
         $display("Test accumulation %0d done", a);
      end
      // Interrupt requests, vectors, global gate, read clear
      acc = 3'h0; wmode = 3'h2; hi = 16'h0; level = 10'h155;
      clear_flags();
      pulse_start();
      wait_rdy();
      @(negedge clk_in);
      ien = 2'h3;
      @(negedge clk_in);
      chk("irq gated", 16'h0, {15'h0, irq});
      gie = 1'b1;
      @(negedge clk_in);
      chk("irq both", 16'h1, {15'h0, irq});
      chk("vector ready", 16'h0, {8'h0, vec});
      rd_in = 1'b1;
      @(negedge clk_in);
      rd_in = 1'b0;
      @(negedge clk_in);
      chk("ready read clear", 16'h0, {15'h0, rdy});
      chk("vector window", 16'h2, {8'h0, vec});
      chk("irq window", 16'h1, {15'h0, irq});
      ien = 2'h1;
      @(negedge clk_in);
      chk("irq masked", 16'h0, {15'h0, irq});
      $display("Test interrupts done");
      // Power-down mid-conversion freezes, then finishes with the result marked invalid
      clear_flags();
      pulse_start();
      repeat (6) @(negedge clk_in);
      pdown = 1'b1;
      repeat (40) @(negedge clk_in);
      chk("frozen ready", 16'h0, {15'h0, rdy});
      pdown = 1'b0;
      wait_rdy();
      chk("invalid mark", 16'h1, {15'h0, inval});
      // Refused starts
      touch = 1'b1;
      refused("touch start");
      touch = 1'b0; pdown = 1'b1;
      refused("power down start");
      pdown = 1'b0; acc = ACC_RESERVED;
      refused("reserved accumulation");
      acc = 3'h0;
      clear_flags();
      pulse_start();
      repeat (4) @(negedge clk_in);
      stby = 1'b1;
      runsb = 1'b1;
      wait_rdy();
      chk("standby finish", 16'h1, {15'h0, rdy});
      refused("standby software start");
      $display("Test refusals done");
      // Event start in standby with run-in-standby, then without it
      estart = 1'b1; level = 10'($urandom_range(1023));
      presc = 3'($urandom_range(2));
      fire = 1'b1;
      @(negedge clk_in);
      fire = 1'b0;
      repeat (5) @(negedge clk_in);
      chk("event start bit", 16'h1, {15'h0, sbit});
      chk("clock request", 16'h1, {15'h0, creq});
      wait_rdy();
      chk("event result", {6'h0, level}, res);
      chk("event start bit end", 16'h0, {15'h0, sbit});
      repeat (2) @(negedge clk_in);
      chk("clock released", 16'h0, {15'h0, creq});
      runsb = 1'b0;
      clear_flags();
      fire = 1'b1;
      @(negedge clk_in);
      fire = 1'b0;
      repeat (60) @(negedge clk_in);
      chk("standby off", 16'h0, {15'h0, rdy});
      $display("Test events done");
      test_done();
   end
endmodule
